//--- logic/atab_bridge.sv
// APB slave that maps task file accesses onto IDE PIO cycles
//
// Added by the designer: the APB register port.
`timescale 1ns/1ps
module atab_bridge
  import atab_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic BUS_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [15:0] IDE_DATA_IN,
  output logic [15:0] IDE_DATA_OUT,
  output logic IDE_DATA_OE_N,
  output logic IDE_READ_N,
  output logic IDE_WRITE_N,
  input wire logic IDE_READY,
  output logic IDE_PRIMARY_SELECT_N,
  output logic IDE_SECONDARY_SELECT_N,
  output logic IDE_ADDR_BIT2,
  output logic IDE_ADDR_BIT1,
  output logic IDE_ADDR_BIT0
);
  // Number of shadowed task registers, error/feature up to drive address
  localparam int NREG = 9;

  atab_bus_e state_r, state_nxt; // APB transfer phase
  logic [31:0] prdata_r, prdata_nxt; // Registered read answer
  logic slverr_r, slverr_nxt; // Registered error answer
  logic [7:0] shadow_r [NREG]; // Last byte seen per register
  logic [7:0] shadow_nxt [NREG];
  logic phase_r, phase_nxt; // Data register: high byte next
  logic [7:0] low_hold_r, low_hold_nxt; // Low byte written, awaiting high
  logic [7:0] high_hold_r, high_hold_nxt; // High byte read, awaiting second read
  logic rd_low_r, rd_low_nxt; // Pending read wants low byte of pair
  int slot_r, slot_nxt; // Shadow slot of pending access

  logic [7:0] idx; // Register index of the access
  logic hit; // Address decodes to a register
  logic [4:0] pattern; // Pin pattern for the index
  logic pio_start; // Kick the PIO engine
  logic pio_write; // PIO direction
  logic [15:0] pio_wdata; // PIO write data
  logic pio_done; // PIO finished
  logic [15:0] pio_rdata; // PIO read data
  logic [4:0] pins; // Registered select and address pins
  int slot; // Shadow slot for the index
  logic access; // Access phase waiting for service

  // Word-aligned decode; index is the byte address divided by four
  assign idx = PADDR[9:2];
  assign access = PSEL && PENABLE;

  // Offset alone picks the selects and address lines
  always_comb
  begin
    hit = 1'b1;
    slot = 0;
    pattern = ATAB_PAT_IDLE;
    case (idx)
      ATAB_IDX_DATA: pattern = ATAB_PAT_DATA;
      ATAB_IDX_ERROR_FEATURE:
      begin
        pattern = ATAB_PAT_ERROR_FEATURE;
        slot = 0;
      end
      ATAB_IDX_SECTOR_COUNT:
      begin
        pattern = ATAB_PAT_SECTOR_COUNT;
        slot = 1;
      end
      ATAB_IDX_SECTOR_NUMBER:
      begin
        pattern = ATAB_PAT_SECTOR_NUMBER;
        slot = 2;
      end
      ATAB_IDX_CYLINDER_LOW:
      begin
        pattern = ATAB_PAT_CYLINDER_LOW;
        slot = 3;
      end
      ATAB_IDX_CYLINDER_HIGH:
      begin
        pattern = ATAB_PAT_CYLINDER_HIGH;
        slot = 4;
      end
      ATAB_IDX_DRIVE_HEAD:
      begin
        pattern = ATAB_PAT_DRIVE_HEAD;
        slot = 5;
      end
      ATAB_IDX_COMMAND:
      begin
        pattern = ATAB_PAT_COMMAND;
        slot = 6;
      end
      ATAB_IDX_ALT_STATUS:
      begin
        pattern = ATAB_PAT_ALT_STATUS;
        slot = 7;
      end
      ATAB_IDX_DRIVE_ADDRESS:
      begin
        pattern = ATAB_PAT_DRIVE_ADDRESS;
        slot = 8;
      end
      default: hit = 1'b0;
    endcase
    // Upper address bits outside the decode make the access unmapped
    if (PADDR[ADDR_W-1:10] != '0 || PADDR[1:0] != 2'h0)
      hit = 1'b0;
  end

  // APB sequencing, shadow update and data register pairing
  always_comb
  begin
    state_nxt = state_r;
    prdata_nxt = prdata_r;
    slverr_nxt = slverr_r;
    shadow_nxt = shadow_r;
    phase_nxt = phase_r;
    low_hold_nxt = low_hold_r;
    high_hold_nxt = high_hold_r;
    rd_low_nxt = rd_low_r;
    slot_nxt = slot_r;
    pio_start = 1'b0;
    pio_write = PWRITE;
    pio_wdata = {8'h00, PWDATA[ATAB_BYTE_LSB +: 8]};
    case (state_r)
      ATAB_IDLE:
      begin
        if (access)
        begin
          // Every answer passes one registered cycle, so PRDATA is a flop
          state_nxt = ATAB_RESP;
          prdata_nxt = 32'h0000_0000;
          slverr_nxt = 1'b0;
          slot_nxt = slot;
          rd_low_nxt = 1'b0;
          if (!hit)
            slverr_nxt = 1'b1;
          else if (idx == ATAB_IDX_DATA)
          begin
            if (PWRITE && !phase_r)
            begin
              // First write only stores the low byte
              low_hold_nxt = PWDATA[ATAB_BYTE_LSB +: 8];
              phase_nxt = 1'b1;
            end
            else if (PWRITE)
            begin
              // Second write issues the 16-bit PIO write
              pio_start = 1'b1;
              pio_wdata = {PWDATA[ATAB_BYTE_LSB +: 8], low_hold_r};
              phase_nxt = 1'b0;
              state_nxt = ATAB_WAIT;
            end
            else if (!phase_r)
            begin
              // First read fetches the word, answers with the low byte
              pio_start = 1'b1;
              rd_low_nxt = 1'b1;
              phase_nxt = 1'b1;
              state_nxt = ATAB_WAIT;
            end
            else
            begin
              // Second read returns the high byte held from the first
              prdata_nxt[ATAB_BYTE_LSB +: 8] = high_hold_r;
              phase_nxt = 1'b0;
            end
          end
          else if (idx == ATAB_IDX_COMMAND && !PWRITE)
            prdata_nxt[ATAB_BYTE_LSB +: 8] = ATAB_CMD_READ_VALUE;
          else
          begin
            // Plain task register: one PIO cycle per access
            pio_start = 1'b1;
            state_nxt = ATAB_WAIT;
            if (PWRITE)
              shadow_nxt[slot] = PWDATA[ATAB_BYTE_LSB +: 8];
          end
        end
      end
      ATAB_WAIT:
      begin
        // Hold the APB access until the peripheral cycle completes
        if (pio_done)
        begin
          state_nxt = ATAB_RESP;
          if (!PWRITE)
          begin
            if (rd_low_r)
            begin
              prdata_nxt[ATAB_BYTE_LSB +: 8] = pio_rdata[7:0];
              high_hold_nxt = pio_rdata[15:8];
            end
            else
            begin
              // Read returns the peripheral byte and refreshes the shadow
              prdata_nxt[ATAB_BYTE_LSB +: 8] = pio_rdata[7:0];
              shadow_nxt[slot_r] = pio_rdata[7:0];
            end
          end
        end
      end
      ATAB_RESP:
        state_nxt = ATAB_IDLE;
      default:
        state_nxt = ATAB_IDLE;
    endcase
    // Bus reset clears the task copies and the byte pairing
    if (BUS_RESET)
    begin
      for (int i = 0; i < NREG; i++)
        shadow_nxt[i] = ATAB_REG_RESET;
      phase_nxt = 1'b0;
      low_hold_nxt = ATAB_REG_RESET;
      high_hold_nxt = ATAB_REG_RESET;
    end
  end

  // Registers only
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      state_r <= ATAB_IDLE;
      prdata_r <= 32'h0000_0000;
      slverr_r <= 1'b0;
      for (int i = 0; i < NREG; i++)
        shadow_r[i] <= ATAB_REG_RESET;
      phase_r <= 1'b0;
      low_hold_r <= ATAB_REG_RESET;
      high_hold_r <= ATAB_REG_RESET;
      rd_low_r <= 1'b0;
      slot_r <= 0;
    end
    else
    begin
      state_r <= state_nxt;
      prdata_r <= prdata_nxt;
      slverr_r <= slverr_nxt;
      shadow_r <= shadow_nxt;
      phase_r <= phase_nxt;
      low_hold_r <= low_hold_nxt;
      high_hold_r <= high_hold_nxt;
      rd_low_r <= rd_low_nxt;
      slot_r <= slot_nxt;
    end
  end

  // Peripheral cycle engine; pins come from its flops
  atab_pio u_pio
  (
    .SYS_CLK(SYS_CLK),
    .RESET(RESET),
    .start(pio_start),
    .write_en(pio_write),
    .pattern(pattern),
    .wdata(pio_wdata),
    .ide_data_in(IDE_DATA_IN),
    .ide_ready(IDE_READY),
    .ide_data_out(IDE_DATA_OUT),
    .ide_data_oe_n(IDE_DATA_OE_N),
    .ide_read_n(IDE_READ_N),
    .ide_write_n(IDE_WRITE_N),
    .ide_pins(pins),
    .done(pio_done),
    .rdata(pio_rdata)
  );

  // Pin fan-out of the registered pattern
  assign IDE_PRIMARY_SELECT_N = pins[ATAB_SEL_PRI];
  assign IDE_SECONDARY_SELECT_N = pins[ATAB_SEL_SEC];
  assign IDE_ADDR_BIT2 = pins[ATAB_SEL_A2];
  assign IDE_ADDR_BIT1 = pins[ATAB_SEL_A1];
  assign IDE_ADDR_BIT0 = pins[ATAB_SEL_A0];

  // Ready only in the answer cycle; master holds the request until then
  assign PREADY = (state_r == ATAB_RESP);
  assign PRDATA = prdata_r;
  assign PSLVERR = slverr_r && (state_r == ATAB_RESP);
endmodule

//--- logic/atab_pkg.sv
// Package with offsets, select patterns, reset values and PIO timing for the task file bridge
// Functional notes
// - Error/feature: primary high, secondary low, 001
// - Sector count: primary high, secondary low, 010
// - Sector number: primary high, secondary low, 011
// - Cylinder low: primary high, secondary low, 100
// - Cylinder high: primary high, secondary low, 101
// - Drive/head: primary high, secondary low, 110
// - Command is write-only, drives address 111
// - Command read returns all-ones byte
// - Alternate status: primary low, secondary high, 110
// - Drive address: primary low, secondary high, 111
// - Offset alone picks selects and address lines
// - Data register: two byte accesses, low first
package atab_pkg;
  // Register indices; byte address on APB is four times the index
  localparam logic [7:0] ATAB_IDX_DATA = 8'h40;
  localparam logic [7:0] ATAB_IDX_COMMAND = 8'h44;
  localparam logic [7:0] ATAB_IDX_ERROR_FEATURE = 8'h48;
  localparam logic [7:0] ATAB_IDX_SECTOR_COUNT = 8'h49;
  localparam logic [7:0] ATAB_IDX_SECTOR_NUMBER = 8'h4A;
  localparam logic [7:0] ATAB_IDX_CYLINDER_LOW = 8'h4B;
  localparam logic [7:0] ATAB_IDX_CYLINDER_HIGH = 8'h4C;
  localparam logic [7:0] ATAB_IDX_DRIVE_HEAD = 8'h4D;
  localparam logic [7:0] ATAB_IDX_ALT_STATUS = 8'h4E;
  localparam logic [7:0] ATAB_IDX_DRIVE_ADDRESS = 8'h4F;
  // Byte lane position of the 8-bit register inside the APB word
  localparam int ATAB_BYTE_LSB = 0;
  // Shadow register reset value, also taken on bus reset
  localparam logic [7:0] ATAB_REG_RESET = 8'h00;
  // Read value of the write-only command register
  localparam logic [7:0] ATAB_CMD_READ_VALUE = 8'hFF;
  // Pin pattern fields: {primary_n, secondary_n, bit2, bit1, bit0}
  localparam int ATAB_SEL_PRI = 4;
  localparam int ATAB_SEL_SEC = 3;
  localparam int ATAB_SEL_A2 = 2;
  localparam int ATAB_SEL_A1 = 1;
  localparam int ATAB_SEL_A0 = 0;
  localparam logic [4:0] ATAB_PAT_DATA = 5'h10;
  localparam logic [4:0] ATAB_PAT_ERROR_FEATURE = 5'h11;
  localparam logic [4:0] ATAB_PAT_SECTOR_COUNT = 5'h12;
  localparam logic [4:0] ATAB_PAT_SECTOR_NUMBER = 5'h13;
  localparam logic [4:0] ATAB_PAT_CYLINDER_LOW = 5'h14;
  localparam logic [4:0] ATAB_PAT_CYLINDER_HIGH = 5'h15;
  localparam logic [4:0] ATAB_PAT_DRIVE_HEAD = 5'h16;
  localparam logic [4:0] ATAB_PAT_COMMAND = 5'h17;
  localparam logic [4:0] ATAB_PAT_ALT_STATUS = 5'h0E;
  localparam logic [4:0] ATAB_PAT_DRIVE_ADDRESS = 5'h0F;
  // Idle pattern: both selects released
  localparam logic [4:0] ATAB_PAT_IDLE = 5'h18;
  // PIO timing in ns and the clock rate
  localparam int ATAB_CLK_MHZ = 200;
  localparam int ATAB_T_SETUP_NS = 70;
  localparam int ATAB_T_STROBE_NS = 165;
  localparam int ATAB_T_RECOVER_NS = 70;
  // Least times round up to whole cycles
  localparam int ATAB_SETUP_CYC = (ATAB_T_SETUP_NS * ATAB_CLK_MHZ + 999) / 1000;
  localparam int ATAB_STROBE_CYC = (ATAB_T_STROBE_NS * ATAB_CLK_MHZ + 999) / 1000;
  localparam int ATAB_RECOVER_CYC = (ATAB_T_RECOVER_NS * ATAB_CLK_MHZ + 999) / 1000;
  // Top-level state of the APB side
  typedef enum logic [1:0] {ATAB_IDLE, ATAB_WAIT, ATAB_RESP} atab_bus_e;
  // PIO engine states
  typedef enum logic [1:0] {ATAB_P_IDLE, ATAB_P_SETUP, ATAB_P_STROBE, ATAB_P_RECOVER} atab_pio_e;
endpackage

//--- logic/atab_pio.sv
// One PIO cycle on the IDE interface: setup, strobe, recovery
`timescale 1ns/1ps
module atab_pio
  import atab_pkg::*;
#(
  parameter int CNT_W = 8
)
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic start,
  input wire logic write_en,
  input wire logic [4:0] pattern,
  input wire logic [15:0] wdata,
  input wire logic [15:0] ide_data_in,
  input wire logic ide_ready,
  output logic [15:0] ide_data_out,
  output logic ide_data_oe_n,
  output logic ide_read_n,
  output logic ide_write_n,
  output logic [4:0] ide_pins,
  output logic done,
  output logic [15:0] rdata
);
  atab_pio_e state_r, state_nxt; // Cycle phase
  logic [CNT_W-1:0] cnt_r, cnt_nxt; // Phase length counter
  logic wr_r, wr_nxt; // Direction of current cycle
  logic [4:0] pins_r, pins_nxt; // Selects and address lines
  logic [15:0] dout_r, dout_nxt; // Write data held on the pins
  logic [15:0] rdata_r, rdata_nxt; // Byte pair caught at strobe end
  logic done_r, done_nxt; // One-cycle completion pulse

  // Next-state logic for one PIO cycle
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    wr_nxt = wr_r;
    pins_nxt = pins_r;
    dout_nxt = dout_r;
    rdata_nxt = rdata_r;
    done_nxt = 1'b0;
    case (state_r)
      ATAB_P_IDLE:
      begin
        if (start)
        begin
          // Address and selects settle before the strobe
          state_nxt = ATAB_P_SETUP;
          cnt_nxt = CNT_W'(ATAB_SETUP_CYC - 1);
          wr_nxt = write_en;
          pins_nxt = pattern;
          dout_nxt = wdata;
        end
      end
      ATAB_P_SETUP:
      begin
        if (cnt_r == '0)
        begin
          state_nxt = ATAB_P_STROBE;
          cnt_nxt = CNT_W'(ATAB_STROBE_CYC - 1);
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      ATAB_P_STROBE:
      begin
        // A slow peripheral stretches the strobe by holding ready low
        if (cnt_r != '0)
          cnt_nxt = cnt_r - 1'b1;
        else if (ide_ready)
        begin
          state_nxt = ATAB_P_RECOVER;
          cnt_nxt = CNT_W'(ATAB_RECOVER_CYC - 1);
          rdata_nxt = ide_data_in;
        end
      end
      ATAB_P_RECOVER:
      begin
        if (cnt_r == '0)
        begin
          state_nxt = ATAB_P_IDLE;
          pins_nxt = ATAB_PAT_IDLE;
          done_nxt = 1'b1;
        end
        else
          cnt_nxt = cnt_r - 1'b1;
      end
      default:
      begin
        state_nxt = ATAB_P_IDLE;
        pins_nxt = ATAB_PAT_IDLE;
      end
    endcase
  end

  // Registers only
  always_ff @(posedge SYS_CLK)
  begin
    if (RESET)
    begin
      state_r <= ATAB_P_IDLE;
      cnt_r <= '0;
      wr_r <= 1'b0;
      pins_r <= ATAB_PAT_IDLE;
      dout_r <= 16'h0000;
      rdata_r <= 16'h0000;
      done_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      wr_r <= wr_nxt;
      pins_r <= pins_nxt;
      dout_r <= dout_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
    end
  end

  // Data bus driven for the whole write cycle, released otherwise
  assign ide_data_oe_n = !(wr_r && state_r != ATAB_P_IDLE);
  assign ide_read_n = !(state_r == ATAB_P_STROBE && !wr_r);
  assign ide_write_n = !(state_r == ATAB_P_STROBE && wr_r);
  assign ide_data_out = dout_r;
  assign ide_pins = pins_r;
  assign done = done_r;
  assign rdata = rdata_r;
endmodule

//--- tb/atab_disk.sv
// Behavioural ATA peripheral answering PIO cycles on the task registers
`timescale 1ns/1ps
module atab_disk (
  input wire logic clk,
  input wire logic slow,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic [4:0] pins,
  input wire logic [15:0] dout,
  output logic [15:0] din,
  output logic rdy
);
  logic [15:0] mem [32]; // Registers by pin pattern
  logic [4:0] last_pat = 5'h00; // Pattern of last finished cycle
  logic [15:0] held = 16'h0000; // Last value driven out
  logic wq = 1'b1; // Write strobe one cycle ago
  logic rq = 1'b1; // Read strobe one cycle ago
  int wcnt = 0; // Finished write cycles
  int rcnt = 0; // Finished read cycles
  int lo = 0; // Cycles of current strobe
  int slen = 0; // Length of the last read strobe in cycles
  // Released bus shows the inverse, so a stale byte never passes
  assign din = !rd_n ? mem[pins] : ~held;
  // Slow mode holds ready low past the nominal strobe, so the stretch really bites
  assign rdy = !(slow && lo < 40);
  // Strobe tracking; a cycle counts when its strobe ends
  always @(posedge clk)
  begin
    lo <= (rd_n && wr_n) ? 0 : lo + 1;
    if (!rd_n)
      held <= mem[pins];
    if (wr_n && !wq) // Whole 16-bit word taken at once
    begin
      mem[pins] <= dout;
      last_pat <= pins;
      wcnt <= wcnt + 1;
    end
    if (rd_n && !rq) // Read cycle done
    begin
      slen <= lo;
      last_pat <= pins;
      rcnt <= rcnt + 1;
    end
    wq <= wr_n;
    rq <= rd_n;
  end
endmodule

//--- tb/atab_bridge_chk.sv
// Assertions on the task register bridge ports
`timescale 1ns/1ps
module atab_bridge_chk #(
  parameter int ADDR_W = 12
)
(
  input wire logic SYS_CLK,
  input wire logic RESET,
  input wire logic BUS_RESET,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [15:0] IDE_DATA_OUT,
  input wire logic IDE_DATA_OE_N,
  input wire logic IDE_READ_N,
  input wire logic IDE_WRITE_N,
  input wire logic IDE_PRIMARY_SELECT_N,
  input wire logic IDE_SECONDARY_SELECT_N,
  input wire logic IDE_ADDR_BIT2,
  input wire logic IDE_ADDR_BIT1,
  input wire logic IDE_ADDR_BIT0
);
  wire logic [4:0] pins; // Selects and address lines together
  assign pins = {IDE_PRIMARY_SELECT_N, IDE_SECONDARY_SELECT_N, IDE_ADDR_BIT2,
    IDE_ADDR_BIT1, IDE_ADDR_BIT0};
  default clocking cb @(posedge SYS_CLK);
  endclocking
  // Either reset aborts whatever is in flight
  default disable iff (RESET || BUS_RESET);
  // A transfer whose strobe is active
  sequence s_pio;
    PSEL && PENABLE && !(IDE_READ_N && IDE_WRITE_N);
  endsequence
  // Read of the command slot
  sequence s_cmd_rd;
    PSEL && !PWRITE && PADDR == 12'h110;
  endsequence
  // Pattern on the pins while strobing a given address
  property p_map(logic [11:0] a, logic [4:0] p);
    s_pio ##0 (PADDR == a) |-> pins == p;
  endproperty
  a_err_feat_map: assert property (p_map(12'h120, 5'b10001))
    else $error("pins wrong at 48h");
  a_sec_cnt_map: assert property (p_map(12'h124, 5'b10010))
    else $error("pins wrong at 49h");
  a_sec_num_map: assert property (p_map(12'h128, 5'b10011))
    else $error("pins wrong at 4Ah");
  a_cyl_low_map: assert property (p_map(12'h12C, 5'b10100))
    else $error("pins wrong at 4Bh");
  a_cyl_high_map: assert property (p_map(12'h130, 5'b10101))
    else $error("pins wrong at 4Ch");
  a_drv_head_map: assert property (p_map(12'h134, 5'b10110))
    else $error("pins wrong at 4Dh");
  a_cmd_map: assert property (p_map(12'h110, 5'b10111))
    else $error("pins wrong at 44h");
  a_alt_stat_map: assert property (p_map(12'h138, 5'b01110))
    else $error("pins wrong at 4Eh");
  a_drv_addr_map: assert property (p_map(12'h13C, 5'b01111))
    else $error("pins wrong at 4Fh");
  a_data_map: assert property (p_map(12'h100, 5'b10000))
    else $error("pins wrong at 40h");
  a_cmd_read_ff: assert property (s_cmd_rd ##0 PREADY |-> PRDATA == 32'h000000FF)
    else $error("command read not FFh");
  a_cmd_no_pio: assert property (s_cmd_rd |-> IDE_READ_N)
    else $error("command read made a PIO read");
  a_idle_pins: assert property (!PSEL |-> pins == 5'b11000)
    else $error("pins not idle");
  a_one_ready: assert property (PREADY |=> !PREADY)
    else $error("ready longer than one cycle");
  a_answer_bound: assert property ($rose(PENABLE) |-> ##[1:200] PREADY)
    else $error("no answer in time");
  a_strobe_min: assert property ($fell(IDE_WRITE_N) |-> (!IDE_WRITE_N) [*8])
    else $error("write strobe too short");
  a_wr_data: assert property (!IDE_WRITE_N && PSEL && PADDR != 12'h100
    |-> IDE_DATA_OUT[7:0] == PWDATA[7:0] && !IDE_DATA_OE_N)
    else $error("write data not on bus");
  a_unmapped_err: assert property (PREADY && PADDR[11:6] != 6'h04 |-> PSLVERR)
    else $error("unmapped access not refused");
endmodule
bind atab_bridge atab_bridge_chk #(.ADDR_W(ADDR_W)) chk_u (.SYS_CLK(SYS_CLK), .RESET(RESET),
  .BUS_RESET(BUS_RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
  .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .IDE_DATA_OUT(IDE_DATA_OUT), .IDE_DATA_OE_N(IDE_DATA_OE_N), .IDE_READ_N(IDE_READ_N),
  .IDE_WRITE_N(IDE_WRITE_N), .IDE_PRIMARY_SELECT_N(IDE_PRIMARY_SELECT_N),
  .IDE_SECONDARY_SELECT_N(IDE_SECONDARY_SELECT_N), .IDE_ADDR_BIT2(IDE_ADDR_BIT2),
  .IDE_ADDR_BIT1(IDE_ADDR_BIT1), .IDE_ADDR_BIT0(IDE_ADDR_BIT0));

//--- tb/tb.sv
// Self-checking bench for the task register bridge
`timescale 1ns/1ps
module tb;
  logic SYS_CLK = 1'b0;
  logic RESET = 1'b1;
  logic BUS_RESET = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h00000000;
  logic [31:0] PRDATA;
  logic PREADY;
  logic PSLVERR;
  logic [15:0] IDE_DATA_IN;
  logic [15:0] IDE_DATA_OUT;
  logic IDE_DATA_OE_N;
  logic IDE_READ_N;
  logic IDE_WRITE_N;
  logic IDE_READY;
  logic IDE_PRIMARY_SELECT_N;
  logic IDE_SECONDARY_SELECT_N;
  logic IDE_ADDR_BIT2;
  logic IDE_ADDR_BIT1;
  logic IDE_ADDR_BIT0;
  logic slow = 1'b0; // Peripheral stretches strobes
  logic [4:0] pins; // Select and address lines together
  logic [31:0] rd; // Last read data
  logic er; // Last error flag
  int errors = 0;
  int checks = 0;
  // Offsets in order, command last as software must
  logic [7:0] idx [9] = '{8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F, 8'h44};
  logic [4:0] pat [9] = '{5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16, 5'h0E, 5'h0F, 5'h17};
  assign pins = {IDE_PRIMARY_SELECT_N, IDE_SECONDARY_SELECT_N, IDE_ADDR_BIT2,
    IDE_ADDR_BIT1, IDE_ADDR_BIT0};
  // 200 MHz clock
  always #2.5 SYS_CLK = ~SYS_CLK;
  atab_bridge dut_u (.SYS_CLK(SYS_CLK), .RESET(RESET), .BUS_RESET(BUS_RESET), .PSEL(PSEL),
    .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .IDE_DATA_IN(IDE_DATA_IN),
    .IDE_DATA_OUT(IDE_DATA_OUT), .IDE_DATA_OE_N(IDE_DATA_OE_N), .IDE_READ_N(IDE_READ_N),
    .IDE_WRITE_N(IDE_WRITE_N), .IDE_READY(IDE_READY),
    .IDE_PRIMARY_SELECT_N(IDE_PRIMARY_SELECT_N),
    .IDE_SECONDARY_SELECT_N(IDE_SECONDARY_SELECT_N), .IDE_ADDR_BIT2(IDE_ADDR_BIT2),
    .IDE_ADDR_BIT1(IDE_ADDR_BIT1), .IDE_ADDR_BIT0(IDE_ADDR_BIT0));
  atab_disk dk (.clk(SYS_CLK), .slow(slow), .rd_n(IDE_READ_N), .wr_n(IDE_WRITE_N),
    .pins(pins), .dout(IDE_DATA_OUT), .din(IDE_DATA_IN), .rdy(IDE_READY));
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic final_report();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // One APB transfer; waits for the answer, bounded
  task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= {24'h000000, d};
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do
    begin
      @(posedge SYS_CLK);
      n++;
    end
    while (PREADY !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      errors++;
      $display("[ERR] pready exp 1 seen 0");
      final_report();
    end
    else
    begin
      rd = PRDATA;
      er = PSLVERR;
      PSEL <= 1'b0;
      PENABLE <= 1'b0;
    end
  endtask
  // Pins idle and outputs quiet after reset
  task automatic t_reset();
    @(posedge SYS_CLK);
    #1;
    chk(pins, 5'h18, "idle pins");
    chk({IDE_READ_N, IDE_WRITE_N, IDE_DATA_OE_N}, 3'b111, "strobes");
    chk(PRDATA, 32'h0, "prdata");
    $display("t_reset done");
  endtask
  // Every task register but data written, all but data and command read back; last two reads stretched
  task automatic t_map();
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, {2'b00, idx[i], 2'b00}, 8'hA0 + i[7:0]);
      chk(dk.last_pat, pat[i], "write pins");
      chk(dk.mem[pat[i]][7:0], 8'hA0 + i[7:0], "write data");
    end
    for (int i = 0; i < 8; i++)
    begin
      slow <= (i > 5);
      apb(1'b0, {2'b00, idx[i], 2'b00}, 8'h00);
      chk(dk.last_pat, pat[i], "read pins");
      chk(rd, 8'hA0 + i[7:0], "read data");
      chk(dk.slen, (i > 5) ? 41 : atab_pkg::ATAB_STROBE_CYC, "strobe length");
    end
    slow <= 1'b0;
    $display("t_map done");
  endtask
  // Command read gives FFh with no cycle; unmapped write refused
  task automatic t_cmd();
    int rc;
    int wc;
    rc = dk.rcnt;
    wc = dk.wcnt;
    apb(1'b0, 12'h110, 8'h00);
    chk(rd, 32'h000000FF, "command read");
    chk(dk.rcnt, rc, "command read cycles");
    apb(1'b1, 12'h0F0, 8'h55);
    chk(er, 1'b1, "unmapped error");
    chk(dk.wcnt, wc, "unmapped cycles");
    $display("t_cmd done");
  endtask
  // Data register byte pairing, and bus reset in mid pair
  task automatic t_data();
    int wc;
    int rc;
    wc = dk.wcnt;
    apb(1'b1, 12'h100, 8'h34);
    chk(dk.wcnt, wc, "low byte held");
    apb(1'b1, 12'h100, 8'h12);
    chk(dk.wcnt, wc + 1, "one word cycle");
    chk(dk.mem[5'h10], 16'h1234, "data word");
    rc = dk.rcnt;
    apb(1'b0, 12'h100, 8'h00);
    chk(rd[7:0], 8'h34, "data low");
    apb(1'b0, 12'h100, 8'h00);
    chk(rd[7:0], 8'h12, "data high");
    chk(dk.rcnt, rc + 1, "one read cycle");
    apb(1'b1, 12'h100, 8'h56);
    @(posedge SYS_CLK);
    BUS_RESET <= 1'b1;
    @(posedge SYS_CLK);
    BUS_RESET <= 1'b0;
    apb(1'b1, 12'h100, 8'h78);
    apb(1'b1, 12'h100, 8'h9A);
    chk(dk.mem[5'h10], 16'h9A78, "pair after bus reset");
    $display("t_data done");
  endtask
  // Main sequence
  initial
  begin
    repeat (3) @(posedge SYS_CLK);
    RESET <= 1'b0;
    t_reset();
    t_map();
    t_cmd();
    t_data();
    final_report();
  end
endmodule
